// ===== block_transfer_pkg.sv
// block_transfer_pkg: constants shared by the block-transfer engine
// assumes a 100 MHz core clock and 16-bit backplane and register words
package block_transfer_pkg;

  localparam int unsigned DATA_W             = 16;
  localparam int unsigned COUNT_W            = 9;
  localparam logic [15:0] MAX_WORDS          = 16'h0100;
  localparam logic [7:0]  MAX_UNIT           = 8'h03;
  localparam logic [7:0]  MAX_SLOT           = 8'h0A;
  localparam int unsigned LOC_UNIT_LSB       = 8;
  localparam logic [7:0]  TX_ERR_CH1_OFFSET  = 8'h11;
  localparam logic [7:0]  TX_ERR_CH2_OFFSET  = 8'h51;
  localparam logic [7:0]  TX_ERR_NONE        = 8'h00;
  localparam logic [7:0]  TX_ERR_NO_TRAILER  = 8'h01;
  localparam logic [15:0] TX_ERR_RESET       = 16'h0000;
  localparam int unsigned CLK_PERIOD_NS      = 10;
  localparam int unsigned NO_ANSWER_TIME_NS  = 10000;
  localparam int unsigned NO_ANSWER_CYCLES   =
    (NO_ANSWER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0]  NO_ANSWER_LAST     = 10'(NO_ANSWER_CYCLES - 1);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_MOVE  = 4'b0100,
    ST_DONE  = 4'b1000
  } state_type;

endpackage

// ===== block_transfer_engine.sv
// block_transfer_engine: moves words between core registers and the buffer
// memory of a plug-in module; also keeps the per-channel transmit error words
// assumes every input is produced on CLK_I by neighbouring logic
`timescale 1ns/1ns
`default_nettype none
module block_transfer_engine
  import block_transfer_pkg::*;
#(
  parameter int unsigned BUF_WORDS = 1024,
  parameter int unsigned REG_WORDS = 8192
)(
  input  wire logic                                    CLK_I,
  input  wire logic                                    RST_N_I,
  input  wire logic                                    TRIGGER_I,
  input  wire logic                                    READ_OP_I,
  input  wire logic                                    SEL_IS_REG_I,
  input  wire logic [15:0]                             SELECTOR_I,
  input  wire logic                                    REG_LOC_VALID_I,
  input  wire logic [15:0]                             REG_LOC_I,
  input  wire logic [15:0]                             BUF_ADDR_I,
  input  wire logic [15:0]                             WORD_COUNT_I,
  input  wire logic [15:0]                             CPU_BASE_I,
  input  wire logic                                    MOD_PRESENT_I,
  output logic                                         BP_REQ_O,
  output logic                                         BP_WRITE_O,
  output logic [15:0]                                  BP_LOC_O,
  output logic [15:0]                                  BP_ADDR_O,
  output logic [block_transfer_pkg::DATA_W-1:0]        BP_WDATA_O,
  input  wire logic                                    BP_ACK_I,
  input  wire logic [block_transfer_pkg::DATA_W-1:0]   BP_RDATA_I,
  output logic                                         REG_RE_O,
  output logic                                         REG_WE_O,
  output logic [15:0]                                  REG_ADDR_O,
  output logic [block_transfer_pkg::DATA_W-1:0]        REG_WDATA_O,
  input  wire logic                                    REG_READY_I,
  input  wire logic [block_transfer_pkg::DATA_W-1:0]   REG_RDATA_I,
  output logic                                         DONE_O,
  output logic                                         INSTRUCTION_ERROR_FLAG_O,
  input  wire logic                                    ERROR_FLAG_CLR_I,
  input  wire logic [1:0]                              TX_NO_TRAILER_I,
  input  wire logic [1:0]                              TX_SENT_OK_I,
  output logic [15:0]                                  TX_ERR_CH1_O,
  output logic [15:0]                                  TX_ERR_CH2_O
);
  import block_transfer_pkg::*;

  state_type             state_reg;
  state_type             state_next;
  logic                  read_reg;
  logic [15:0]           sel_reg;
  logic                  sel_is_reg_reg;
  logic [15:0]           buf_addr_reg;
  logic [15:0]           count_reg;
  logic [15:0]           cpu_base_reg;
  logic [15:0]           src_addr_reg;
  logic [15:0]           snk_addr_reg;
  logic [COUNT_W-1:0]    src_left_reg;
  logic [COUNT_W-1:0]    snk_left_reg;
  logic [9:0]            wait_reg;
  logic                  done_reg;
  logic                  err_flag_reg;
  logic [7:0]            tx_code_reg [2];
  logic [DATA_W-1:0]     fifo_mem_reg [2];
  logic                  fifo_wr_reg;
  logic                  fifo_rd_reg;
  logic [1:0]            fifo_cnt_reg;

  // range check used for both the buffer side and the register side
  function automatic logic range_ok(input logic [15:0] base, input logic [15:0] cnt,
                                    input int unsigned limit);
    logic [16:0] top;
    top = {1'b0, base} + {1'b0, cnt};
    range_ok = (top <= 17'(limit));
  endfunction

  // operand checks, evaluated in ST_CHECK on captured operands
  wire        const_sel_ok = (sel_reg[15:LOC_UNIT_LSB] <= MAX_UNIT)
                          && (sel_reg[LOC_UNIT_LSB-1:0] <= MAX_SLOT);
  wire        sel_ok       = sel_is_reg_reg ? REG_LOC_VALID_I : const_sel_ok;
  wire        count_ok     = (count_reg <= MAX_WORDS);
  wire        buf_ok       = range_ok(buf_addr_reg, count_reg, BUF_WORDS);
  wire        cpu_ok       = range_ok(cpu_base_reg, count_reg, REG_WORDS);
  wire        check_fail   = !sel_ok || !MOD_PRESENT_I || !count_ok
                          || !buf_ok || !cpu_ok;
  wire        in_move      = (state_reg == ST_MOVE);
  wire        in_check     = (state_reg == ST_CHECK);

  // two-entry buffer between source and sink so a stalled sink loses nothing
  wire        fifo_in_ready = (fifo_cnt_reg != 2'h2);
  wire        fifo_out_valid = (fifo_cnt_reg != 2'h0);
  wire [DATA_W-1:0] fifo_head = fifo_mem_reg[fifo_rd_reg];

  wire        src_req  = in_move && (src_left_reg != '0) && fifo_in_ready;
  wire        src_fire = src_req && (read_reg ? BP_ACK_I : REG_READY_I);
  wire        snk_req  = in_move && fifo_out_valid;
  wire        snk_fire = snk_req && (read_reg ? REG_READY_I : BP_ACK_I);
  wire [DATA_W-1:0] fifo_in_data = read_reg ? BP_RDATA_I : REG_RDATA_I;

  // backplane: read fetches as source, write stores as sink
  wire        bp_req   = read_reg ? src_req : snk_req;
  wire        no_answer = bp_req && !BP_ACK_I && (wait_reg == NO_ANSWER_LAST);
  wire        move_fail = in_move && (no_answer || !MOD_PRESENT_I);
  wire        move_end  = in_move && (snk_left_reg == '0) && !move_fail;
  wire        flush     = !in_move;

  assign BP_REQ_O    = bp_req;
  assign BP_WRITE_O  = !read_reg;
  assign BP_LOC_O    = sel_is_reg_reg ? REG_LOC_I : sel_reg;
  assign BP_ADDR_O   = read_reg ? src_addr_reg : snk_addr_reg;
  assign BP_WDATA_O  = fifo_head;
  assign REG_RE_O    = !read_reg && src_req;
  assign REG_WE_O    = read_reg && snk_req;
  assign REG_ADDR_O  = read_reg ? snk_addr_reg : src_addr_reg;
  assign REG_WDATA_O = fifo_head;
  assign DONE_O      = done_reg;
  assign INSTRUCTION_ERROR_FLAG_O = err_flag_reg;
  assign TX_ERR_CH1_O = {8'h00, tx_code_reg[0]};
  assign TX_ERR_CH2_O = {8'h00, tx_code_reg[1]};

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:  if (TRIGGER_I) state_next = ST_CHECK;
      ST_CHECK: state_next = check_fail ? ST_DONE : ST_MOVE;
      ST_MOVE:  if (move_fail || move_end) state_next = ST_DONE;
      ST_DONE:  if (!TRIGGER_I) state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
      state_reg <= ST_IDLE;
    else
      state_reg <= state_next;
  end

  // operands are frozen at the trigger so a changing ladder cannot tear a transfer, except a register-held location read live from REG_LOC_I
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      read_reg       <= 1'b1;
      sel_reg        <= '0;
      sel_is_reg_reg <= 1'b0;
      buf_addr_reg   <= '0;
      count_reg      <= '0;
      cpu_base_reg   <= '0;
    end
    else if (state_reg == ST_IDLE && TRIGGER_I)
    begin
      read_reg       <= READ_OP_I;
      sel_reg        <= SELECTOR_I;
      sel_is_reg_reg <= SEL_IS_REG_I;
      buf_addr_reg   <= BUF_ADDR_I;
      count_reg      <= WORD_COUNT_I;
      cpu_base_reg   <= CPU_BASE_I;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      src_addr_reg <= '0;
      snk_addr_reg <= '0;
      src_left_reg <= '0;
      snk_left_reg <= '0;
    end
    else if (in_check)
    begin
      src_addr_reg <= read_reg ? buf_addr_reg : cpu_base_reg;
      snk_addr_reg <= read_reg ? cpu_base_reg : buf_addr_reg;
      src_left_reg <= count_reg[COUNT_W-1:0];
      snk_left_reg <= count_reg[COUNT_W-1:0];
    end
    else
    begin
      if (src_fire)
      begin
        src_addr_reg <= src_addr_reg + 16'h0001;
        src_left_reg <= src_left_reg - 9'h001;
      end
      if (snk_fire)
      begin
        snk_addr_reg <= snk_addr_reg + 16'h0001;
        snk_left_reg <= snk_left_reg - 9'h001;
      end
    end
  end

  // answer watchdog restarts on every acknowledged backplane access
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I || !bp_req || BP_ACK_I)
      wait_reg <= '0;
    else
      wait_reg <= wait_reg + 10'h001;
  end

  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I || flush)
    begin
      fifo_wr_reg  <= 1'b0;
      fifo_rd_reg  <= 1'b0;
      fifo_cnt_reg <= 2'h0;
    end
    else
    begin
      if (src_fire)
      begin
        fifo_mem_reg[fifo_wr_reg] <= fifo_in_data;
        fifo_wr_reg <= !fifo_wr_reg;
      end
      if (snk_fire)
        fifo_rd_reg <= !fifo_rd_reg;
      fifo_cnt_reg <= fifo_cnt_reg + {1'b0, src_fire} - {1'b0, snk_fire};
    end
  end

  // error flag: a new failure in the clear cycle keeps the flag set
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      done_reg     <= 1'b0;
      err_flag_reg <= 1'b0;
    end
    else
    begin
      done_reg <= (state_next == ST_DONE);
      if ((in_check && check_fail) || move_fail)
        err_flag_reg <= 1'b1;
      else if (ERROR_FLAG_CLR_I)
        err_flag_reg <= 1'b0;
    end
  end

  // transmit error codes; missing trailer beats a same-cycle good send
  always_ff @(posedge CLK_I)
  begin
    if (!RST_N_I)
    begin
      tx_code_reg[0] <= TX_ERR_RESET[7:0];
      tx_code_reg[1] <= TX_ERR_RESET[7:0];
    end
    else
    begin
      for (int ch = 0; ch < 2; ch++)
      begin
        if (TX_NO_TRAILER_I[ch])
          tx_code_reg[ch] <= TX_ERR_NO_TRAILER;
        else if (TX_SENT_OK_I[ch])
          tx_code_reg[ch] <= TX_ERR_NONE;
      end
    end
  end

endmodule
`default_nettype wire

// ===== engine_props.sv
// engine_props: port-level checks for the block-transfer engine
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module engine_props
  import block_transfer_pkg::*;
(
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic        TRIGGER_I,
  input wire logic        SEL_IS_REG_I,
  input wire logic [15:0] SELECTOR_I,
  input wire logic [15:0] WORD_COUNT_I,
  input wire logic        BP_REQ_O,
  input wire logic        BP_WRITE_O,
  input wire logic [15:0] BP_ADDR_O,
  input wire logic        BP_ACK_I,
  input wire logic        DONE_O,
  input wire logic        INSTRUCTION_ERROR_FLAG_O,
  input wire logic [1:0]  TX_NO_TRAILER_I,
  input wire logic [1:0]  TX_SENT_OK_I,
  input wire logic [15:0] TX_ERR_CH1_O,
  input wire logic [15:0] TX_ERR_CH2_O
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // idle inferred from done low: done only clears after trigger drops
  sequence start_s;
    !DONE_O && $rose(TRIGGER_I);
  endsequence
  sequence reject_s;
    ##2 INSTRUCTION_ERROR_FLAG_O && DONE_O;
  endsequence
  a_done_falls: assert property (DONE_O && !TRIGGER_I |=> !DONE_O)
    else $error("done held with trigger off");
  a_count_limit: assert property (start_s ##0 WORD_COUNT_I > MAX_WORDS |-> reject_s)
    else $error("long count not rejected");
  a_slot_range: assert property (start_s ##0 !SEL_IS_REG_I &&
    SELECTOR_I[7:0] > MAX_SLOT |-> reject_s) else $error("bad slot not rejected");
  a_unit_range: assert property (start_s ##0 !SEL_IS_REG_I &&
    SELECTOR_I[15:8] > MAX_UNIT |-> reject_s) else $error("bad unit not rejected");
  a_no_access: assert property (start_s ##0 WORD_COUNT_I > MAX_WORDS |-> !BP_REQ_O [*3])
    else $error("rejected op reached backplane");
  a_req_stable: assert property (BP_REQ_O && !BP_ACK_I |=>
    !BP_REQ_O || $stable(BP_ADDR_O) && $stable(BP_WRITE_O)) else $error("request moved");
  a_tx_trailer: assert property (TX_NO_TRAILER_I[0] |=> TX_ERR_CH1_O[7:0] == TX_ERR_NO_TRAILER)
    else $error("trailer code missing");
  a_tx_ok: assert property (TX_SENT_OK_I[1] && !TX_NO_TRAILER_I[1] |=>
    TX_ERR_CH2_O[7:0] == TX_ERR_NONE) else $error("ok code missing");
  a_tx_upper: assert property (TX_ERR_CH1_O[15:8] == 8'h00 && TX_ERR_CH2_O[15:8] == 8'h00)
    else $error("upper byte not zero");
endmodule
bind block_transfer_engine engine_props engine_props_i (.*);
`default_nettype wire

// ===== bp_memory_model.sv
// bp_memory_model: plug-in module buffer memory on the backplane
// assumes requests held until the one-cycle ack is sampled
`timescale 1ns/1ns
`default_nettype none
module bp_memory_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic        write_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        mute_i,
  input  wire logic        slow_i,
  output logic             ack_o,
  output logic [15:0]      rdata_o
);
  logic [15:0] mem [0:63];
  logic [15:0] last_reg = 16'h0000;
  logic [1:0]  wait_reg = 2'h0;
  initial ack_o = 1'b0;
  // idle bus shows inverted last value so a stale sample is caught
  assign rdata_o = ack_o ? mem[addr_i[5:0]] : ~last_reg;
  always @(posedge clk_i)
  begin
    ack_o <= 1'b0;
    if (ack_o)
    begin
      last_reg <= mem[addr_i[5:0]];
      if (write_i)
        mem[addr_i[5:0]] <= wdata_i;
    end
    else if (req_i && !mute_i)
    begin
      wait_reg <= (slow_i && wait_reg != 2'h2) ? wait_reg + 2'h1 : 2'h0;
      ack_o <= !slow_i || wait_reg == 2'h2;
    end
  end
endmodule
`default_nettype wire

// ===== tb_top.sv
// tb_top: directed transfers, rejections and transmit error words
// assumes the engine and the buffer memory model are compiled first
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clk, rst_n = 0, trig = 0, rd = 0, is_reg = 0, present = 1, clr = 0, mute = 0, slow = 0;
  logic [15:0] sel = 0, buf_a = 0, cnt = 0, base = 0, bp_loc, bp_addr, bp_wd, rdata, raddr, rwd;
  logic [15:0] tx1, tx2;
  logic [1:0]  no_tr = 0, ok_tx = 0;
  logic        req, wr, ack, re, we, done, flag;
  logic        loc_ok = 0;
  logic [15:0] rf [0:255];
  int          err_count = 0, n_checks = 0;
  block_transfer_engine block_transfer_engine_i (.CLK_I(clk), .RST_N_I(rst_n),
    .TRIGGER_I(trig), .READ_OP_I(rd), .SEL_IS_REG_I(is_reg), .SELECTOR_I(sel),
    .REG_LOC_VALID_I(loc_ok), .REG_LOC_I(16'h0001), .BUF_ADDR_I(buf_a), .WORD_COUNT_I(cnt),
    .CPU_BASE_I(base), .MOD_PRESENT_I(present), .BP_REQ_O(req), .BP_WRITE_O(wr),
    .BP_LOC_O(bp_loc), .BP_ADDR_O(bp_addr), .BP_WDATA_O(bp_wd), .BP_ACK_I(ack),
    .BP_RDATA_I(rdata), .REG_RE_O(re), .REG_WE_O(we), .REG_ADDR_O(raddr),
    .REG_WDATA_O(rwd), .REG_READY_I(re | we), .REG_RDATA_I(rf[raddr[7:0]]), .DONE_O(done),
    .INSTRUCTION_ERROR_FLAG_O(flag), .ERROR_FLAG_CLR_I(clr), .TX_NO_TRAILER_I(no_tr),
    .TX_SENT_OK_I(ok_tx), .TX_ERR_CH1_O(tx1), .TX_ERR_CH2_O(tx2));
  bp_memory_model bp_memory_model_i (.clk_i(clk), .req_i(req), .write_i(wr),
    .addr_i(bp_addr), .wdata_i(bp_wd), .mute_i(mute), .slow_i(slow), .ack_o(ack),
    .rdata_o(rdata));
  always @(posedge clk)
    if (we)
      rf[raddr[7:0]] <= rwd;
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic run(input logic r, input logic [15:0] s, b, c, a);
    int n;
    @(negedge clk);
    {rd, sel, buf_a, cnt, base, trig} = {r, s, b, c, a, 1'b1};
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge clk);
      n++;
    end
    chk("done raised", 16'h0001, {15'h0, done});
    trig = 0;
    repeat (2) @(negedge clk);
    chk("done after release", 16'h0000, {15'h0, done});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #200000;
    err_count++;
    final_report();
  end
  initial
  begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    chk("tx1 at reset", 16'h0000, tx1);
    {rf[16], rf[17], rf[64]} = {16'hA5C3, 16'h3C5A, 16'hDEAD};
    run(0, 16'h030A, 16'h0004, 16'h0002, 16'h0010);
    chk("buf word 4", 16'hA5C3, bp_memory_model_i.mem[4]);
    chk("buf word 5", 16'h3C5A, bp_memory_model_i.mem[5]);
    chk("module location", 16'h030A, bp_loc);
    {slow, is_reg, loc_ok} = 3'b111;
    run(1, 16'h030A, 16'h0004, 16'h0002, 16'h0020);
    chk("reg word 32", 16'hA5C3, rf[32]);
    chk("reg word 33", 16'h3C5A, rf[33]);
    chk("register location", 16'h0001, bp_loc);
    {is_reg, loc_ok} = 2'b00;
    chk("flag clear", 16'h0000, {15'h0, flag});
    $display("test transfer done");
    for (int i = 0; i < 8; i++)
    begin
      {is_reg, present, mute} = {i == 3, i != 4, i == 7};
      run(i[0], i == 1 ? 16'h000B : i == 2 ? 16'h0400 : 16'h0001,
        i == 5 ? 16'h03FF : 16'h0000, i == 0 ? 16'h0101 : 16'h0002,
        i == 6 ? 16'h1FFF : 16'h0040);
      chk("reject flag", 16'h0001, {15'h0, flag});
      chk("reg untouched", 16'hDEAD, rf[64]);
      clr = 1;
      @(negedge clk);
      clr = 0;
    end
    mute = 0;
    $display("test rejections done");
    no_tr = 2'b11;
    @(negedge clk);
    {no_tr, ok_tx} = {2'b01, 2'b11};
    @(negedge clk);
    {no_tr, ok_tx} = 4'h0;
    chk("tx1 code", 16'h0001, tx1);
    chk("tx2 code", 16'h0000, tx2);
    $display("test transmit error done");
    final_report();
  end
endmodule
`default_nettype wire
